// >>> verilog/sbeu_top.sv
// event channel qualifier, action router and sequential break unit
module sbeu_top (
  input logic clk,
  input logic rst,
  input sbeu_pkg::sbeu_cpu_mode_t cpuMode,
  input sbeu_pkg::sbeu_sys_mode_t sysMode,
  input logic [sbeu_pkg::NCH-1:0][sbeu_pkg::NCOND-1:0] condUse,
  input logic [sbeu_pkg::NCH-1:0][sbeu_pkg::NCOND-1:0] condHit,
  input logic [sbeu_pkg::NCH-1:0] countEn,
  input logic [sbeu_pkg::NCH-1:0][sbeu_pkg::CNTW-1:0] countTarget,
  input logic [sbeu_pkg::NCH-1:0] breakEn,
  input logic [sbeu_pkg::NCH-1:0] traceEn,
  input logic [sbeu_pkg::NCH-1:0] perfStartEn,
  input logic [sbeu_pkg::NCH-1:0] perfStopEn,
  input logic [sbeu_pkg::NCH-1:0][sbeu_pkg::CHW-1:0] predSel,
  input logic [sbeu_pkg::NCH-1:0] flagSetEn,
  input logic [sbeu_pkg::NCH-1:0] flagClrEn,
  input logic swTraceEn,
  input logic swTraceHit,
  output logic haltReq,
  output logic [sbeu_pkg::NCH-1:0] traceReq,
  output logic perfStart,
  output logic perfStop,
  output logic swTraceReq,
  output logic cpuMatchFlag,
  output logic [sbeu_pkg::NCH-1:0] chanSat,
  output logic [sbeu_pkg::STGW-1:0] cpuStage,
  output logic [sbeu_pkg::STGW-1:0] sysStage
);
  import sbeu_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic sbeu_order_t cpuOrder(input sbeu_cpu_mode_t m);
    sbeu_order_t o;
    o = '0;
    case (m)
      CPU_2_1: o[1:0] = {CH1, CH2};
      CPU_4_3: o[1:0] = {CH3, CH4};
      CPU_6_5: o[1:0] = {CH5, CH6};
      CPU_11_10: o[1:0] = {CH10, CH11};
      CPU_CH3: o[2:0] = {CH1, CH2, CH3};
      CPU_CH4: o[3:0] = {CH1, CH2, CH3, CH4};
      CPU_CH5: o[4:0] = {CH1, CH2, CH3, CH4, CH5};
      CPU_CH6: o[5:0] = {CH1, CH2, CH3, CH4, CH5, CH6};
      CPU_CH7: o[6:0] = {CH1, CH2, CH3, CH4, CH5, CH6, CH10};
      CPU_CH8: o[7:0] = {CH1, CH2, CH3, CH4, CH5, CH6, CH10, CH11};
      default: o = '0;
    endcase
    return o;
  endfunction

  function automatic logic [LENW-1:0] cpuLen(input sbeu_cpu_mode_t m);
    case (m)
      CPU_2_1, CPU_4_3, CPU_6_5, CPU_11_10: return 4'h2;
      CPU_CH3: return 4'h3;
      CPU_CH4: return 4'h4;
      CPU_CH5: return 4'h5;
      CPU_CH6: return 4'h6;
      CPU_CH7: return 4'h7;
      CPU_CH8: return 4'h8;
      default: return 4'h0;
    endcase
  endfunction

  function automatic sbeu_order_t sysOrder(input sbeu_sys_mode_t m);
    sbeu_order_t o;
    o = '0;
    case (m)
      SYS_9_8: o[1:0] = {CH8, CH9};
      SYS_8_9: o[1:0] = {CH9, CH8};
      SYS_18_17: o[1:0] = {CH17, CH18};
      SYS_17_18: o[1:0] = {CH18, CH17};
      default: o = '0;
    endcase
    return o;
  endfunction

  // slots taking part in a fixed chain; used for both sides
  function automatic logic [NCH-1:0] members(input sbeu_order_t o, input logic [LENW-1:0] n);
    logic [NCH-1:0] m;
    m = '0;
    for (int k = 0; k < SEQD; k++) begin
      if (k < int'(n)) begin
        m[o[k]] = 1'b1;
      end
    end
    return m;
  endfunction

  // ----------------------------------------
  // channel qualification
  // ----------------------------------------
  logic [NCH-1:0] qualRaw;
  logic [NCH-1:0] countHit;
  logic [NCH-1:0] countOn;
  logic [NCH-1:0] qual;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      logic [NCOND-1:0] used;
      // kinds outside the capability matrix are ignored even if selected
      assign used = condUse[g] & COND_CAP[g];
      assign qualRaw[g] = (|used) && (&(~used | condHit[g]));
      assign countOn[g] = countEn[g] && CAP_COUNT[g];
      if (CAP_COUNT[g]) begin : g_cnt
        logic [CNTW-1:0] cnt_q;
        assign countHit[g] = ({1'b0, cnt_q} + 9'h001) >= {1'b0, countTarget[g]};
        always_ff @(posedge clk) begin
          if (rst || haltReq) begin
            cnt_q <= CNT_RST;
          end else if (qualRaw[g] && countOn[g]) begin
            cnt_q <= countHit[g] ? CNT_RST : cnt_q + 8'h01;
          end
        end
      end else begin : g_nocnt
        assign countHit[g] = 1'b1;
      end
      assign qual[g] = qualRaw[g] && (!countOn[g] || countHit[g]);
    end
  endgenerate

  // ----------------------------------------
  // extended sequencing
  // ----------------------------------------
  logic [NCH-1:0] extOn;
  logic [NCH-1:0] predOk;
  logic [NCH-1:0] isPred;
  logic [NCH-1:0] fire;
  logic [NCH-1:0] extFire;
  logic [NCH-1:0] flagPred;
  logic [NCH-1:0] sat_q;
  logic flag_q;
  logic setHit;
  logic clrHit;

  generate
    for (g = 0; g < NCH; g++) begin : g_ext
      assign extOn[g] = SYS_GROUP[g] ? (sysMode == SYS_EXT) : (cpuMode == CPU_EXT);
      assign flagPred[g] = (predSel[g] == PRED_FLAG);
      assign predOk[g] = (predSel[g] == PRED_NONE) || (flagPred[g] && flag_q)
        || (!flagPred[g] && sat_q[predSel[g] - 4'h1]);
      assign fire[g] = qual[g] && (!extOn[g] || predOk[g]);
    end
  endgenerate

  assign extFire = fire & extOn;

  always_comb begin
    isPred = '0;
    for (int i = 0; i < NCH; i++) begin
      if (extOn[i] && predSel[i] != PRED_NONE && !flagPred[i]) begin
        isPred[predSel[i] - 4'h1] = 1'b1;
      end
    end
  end

  assign setHit = |(extFire & flagSetEn);
  assign clrHit = |(extFire & flagClrEn);

  // a new satisfaction in the halt cycle survives, so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      sat_q <= SAT_RST;
    end else if (haltReq) begin
      sat_q <= extFire;
    end else begin
      sat_q <= sat_q | extFire;
    end
  end

  // set beats clear, and both beat the break reset
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (setHit) begin
      flag_q <= 1'b1;
    end else if (clrHit || haltReq) begin
      flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // fixed chains
  // ----------------------------------------
  sbeu_order_t cpuSeq;
  sbeu_order_t sysSeq;
  logic [LENW-1:0] cpuSeqLen;
  logic [LENW-1:0] sysSeqLen;
  logic [NCH-1:0] inChain;
  logic cpuDone;
  logic sysDone;

  assign cpuSeq = cpuOrder(cpuMode);
  assign cpuSeqLen = cpuLen(cpuMode);
  assign sysSeq = sysOrder(sysMode);
  assign sysSeqLen = (sysMode == SYS_OFF || sysMode == SYS_EXT) ? 4'h0 : 4'h2;
  // chain members advance the chain but keep their trace and perf actions; their own break is held back
  assign inChain = members(cpuSeq, cpuSeqLen) | members(sysSeq, sysSeqLen);

  sbeu_seq_tracker u_cpu_seq (
    .clk(clk),
    .rst(rst),
    .hit(fire),
    .order(cpuSeq),
    .len(cpuSeqLen),
    .clear(haltReq),
    .done(cpuDone),
    .stage(cpuStage)
  );

  sbeu_seq_tracker u_sys_seq (
    .clk(clk),
    .rst(rst),
    .hit(fire),
    .order(sysSeq),
    .len(sysSeqLen),
    .clear(haltReq),
    .done(sysDone),
    .stage(sysStage)
  );

  // ----------------------------------------
  // actions
  // ----------------------------------------
  logic [NCH-1:0] chanBreak;
  logic halt_q;
  logic [NCH-1:0] trace_q;
  logic perfStart_q;
  logic perfStop_q;
  logic swTrace_q;

  assign chanBreak = fire & (breakEn | BREAK_FIXED) & CAP_BREAK
    & ~inChain & ~isPred;

  always_ff @(posedge clk) begin
    if (rst) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= (|chanBreak) || cpuDone || sysDone;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trace_q <= '0;
      swTrace_q <= 1'b0;
    end else begin
      trace_q <= fire & traceEn & CAP_TRACE;
      swTrace_q <= swTraceEn && swTraceHit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      perfStart_q <= 1'b0;
      perfStop_q <= 1'b0;
    end else begin
      perfStart_q <= |(fire & perfStartEn & CAP_PERF);
      perfStop_q <= |(fire & perfStopEn & CAP_PERF);
    end
  end

  assign haltReq = halt_q;
  assign traceReq = trace_q;
  assign perfStart = perfStart_q;
  assign perfStop = perfStop_q;
  assign swTraceReq = swTrace_q;
  assign cpuMatchFlag = flag_q;
  assign chanSat = sat_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ch9_trace_a: assert property (fire[CH9] && traceEn[CH9] |=> traceReq[CH9])
    else $error("channel 9 trace action lost");
  no_trace_bp_a: assert property ((traceReq & ~CAP_TRACE) == '0)
    else $error("trace raised on a channel without trace action");
  sw_trace_a: assert property (
    (swTraceEn && swTraceHit) |=> swTraceReq ##1 (swTraceReq == $past(swTraceEn && swTraceHit)))
    else $error("software trace request wrong");
  lone_break_a: assert property (chanBreak != '0 |=> haltReq)
    else $error("channel break did not halt");
  pair_guard_a: assert property (
    cpuMode == CPU_2_1 && sysMode == SYS_OFF && cpuStage == STAGE_RST && chanBreak == '0
      |=> !haltReq)
    else $error("pair 2 then 1 halted out of order");
  cpu_done_a: assert property (cpuDone |=> haltReq ##1 cpuStage == STAGE_RST)
    else $error("finished chain did not halt and restart");
  sys_done_a: assert property (sysDone |=> haltReq)
    else $error("system bus chain did not halt");
  sat_clear_a: assert property (haltReq |=> (chanSat & ~$past(extFire)) == '0)
    else $error("progress survived a halt");
  flag_init_a: assert property (haltReq && !setHit |=> !cpuMatchFlag)
    else $error("match flag not reset by break");
  flag_set_a: assert property (setHit |=> cpuMatchFlag)
    else $error("match flag not set");
  pred_wait_a: assert property (|(extFire & flagPred) |-> cpuMatchFlag)
    else $error("flag predecessor fired without flag");
  pred_quiet_a: assert property (
    (fire & isPred) != '0 && (fire & ~isPred) == '0 && !cpuDone && !sysDone |=> !haltReq)
    else $error("predecessor channel halted by itself");
  count_gate_a: assert property (
    qualRaw[CH11] && countOn[CH11] && !countHit[CH11] |-> !fire[CH11])
    else $error("channel 11 fired before its count");
  ch7_break_a: assert property (
    fire[CH7] && !inChain[CH7] && !isPred[CH7] |=> haltReq)
    else $error("channel 7 match did not halt");
  ext_pred_a: assert property (
    extOn[CH1] && predSel[CH1] == 4'h2 && fire[CH1] |-> chanSat[CH2])
    else $error("channel 1 fired before its predecessor");
  sys_order_a: assert property (
    sysMode == SYS_9_8 && cpuMode == CPU_OFF && sysStage == STAGE_RST && chanBreak == '0
      |=> !haltReq)
    else $error("pair 9 then 8 halted out of order");
endmodule

// >>> pkg/sbeu_pkg.sv
// shared constants and types for the sequential break event unit
package sbeu_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NCH = 14;
  localparam int NCOND = 8;
  localparam int CHW = 4;
  localparam int CNTW = 8;
  localparam int SEQD = 8;
  localparam int STGW = 3;
  localparam int LENW = 4;

  // ----------------------------------------
  // condition kinds, one bit each
  // ----------------------------------------
  localparam int C_ADDR = 0;
  localparam int C_DATA = 1;
  localparam int C_ASID = 2;
  localparam int C_BUS = 3;
  localparam int C_WIN = 4;
  localparam int C_SYS = 5;
  localparam int C_TLBLOAD = 6;
  localparam int C_BRANCH = 7;

  // ----------------------------------------
  // channel slots
  // ----------------------------------------
  localparam logic [CHW-1:0] CH1 = 4'h0;
  localparam logic [CHW-1:0] CH2 = 4'h1;
  localparam logic [CHW-1:0] CH3 = 4'h2;
  localparam logic [CHW-1:0] CH4 = 4'h3;
  localparam logic [CHW-1:0] CH5 = 4'h4;
  localparam logic [CHW-1:0] CH6 = 4'h5;
  localparam logic [CHW-1:0] CH7 = 4'h6;
  localparam logic [CHW-1:0] CH8 = 4'h7;
  localparam logic [CHW-1:0] CH9 = 4'h8;
  localparam logic [CHW-1:0] CH10 = 4'h9;
  localparam logic [CHW-1:0] CH11 = 4'hA;
  localparam logic [CHW-1:0] CH12 = 4'hB;
  localparam logic [CHW-1:0] CH17 = 4'hC;
  localparam logic [CHW-1:0] CH18 = 4'hD;

  // predecessor selector codes: slot plus one, or the match flag
  localparam logic [CHW-1:0] PRED_NONE = 4'h0;
  localparam logic [CHW-1:0] PRED_FLAG = 4'hF;

  // ----------------------------------------
  // capability matrix, channel 18 first
  // ----------------------------------------
  localparam logic [NCH-1:0][NCOND-1:0] COND_CAP = {
    8'h21, 8'h21, 8'h80, 8'h0F, 8'h0D, 8'h21, 8'h21,
    8'h40, 8'h1C, 8'h1C, 8'h05, 8'h05, 8'h0F, 8'h0D};
  localparam logic [NCH-1:0] CAP_COUNT = 14'h0402;
  localparam logic [NCH-1:0] CAP_BREAK = 14'h3FFF;
  localparam logic [NCH-1:0] CAP_TRACE = 14'h39B0;
  localparam logic [NCH-1:0] CAP_PERF = 14'h3FBF;
  localparam logic [NCH-1:0] BREAK_FIXED = 14'h0040;
  localparam logic [NCH-1:0] SYS_GROUP = 14'h3180;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [CNTW-1:0] CNT_RST = 8'h00;
  localparam logic [STGW-1:0] STAGE_RST = 3'h0;
  localparam logic [NCH-1:0] SAT_RST = 14'h0000;

  // ----------------------------------------
  // modes
  // ----------------------------------------
  typedef enum logic [3:0] {
    CPU_OFF, CPU_2_1, CPU_4_3, CPU_6_5, CPU_11_10,
    CPU_CH3, CPU_CH4, CPU_CH5, CPU_CH6, CPU_CH7, CPU_CH8, CPU_EXT
  } sbeu_cpu_mode_t;

  typedef enum logic [2:0] {
    SYS_OFF, SYS_9_8, SYS_8_9, SYS_18_17, SYS_17_18, SYS_EXT
  } sbeu_sys_mode_t;

  typedef logic [SEQD-1:0][CHW-1:0] sbeu_order_t;

endpackage

// >>> verilog/sbeu_seq_tracker.sv
// ordered chain tracker: walks a list of channel slots one match at a time
module sbeu_seq_tracker (
  input logic clk,
  input logic rst,
  input logic [sbeu_pkg::NCH-1:0] hit,
  input sbeu_pkg::sbeu_order_t order,
  input logic [sbeu_pkg::LENW-1:0] len,
  input logic clear,
  output logic done,
  output logic [sbeu_pkg::STGW-1:0] stage
);
  import sbeu_pkg::*;

  logic [STGW-1:0] stage_q;
  logic [STGW-1:0] stage_d;
  logic isLast;
  logic wantHit;

  // a zero length leaves the tracker idle
  assign wantHit = (len != 4'h0) && hit[order[stage_q]];
  assign isLast = ({1'b0, stage_q} == len - 4'h1);
  assign done = wantHit && isLast && !clear;
  assign stage = stage_q;

  // ----------------------------------------
  // stage register
  // ----------------------------------------
  // only the channel awaited now moves the chain; out-of-order hits are ignored
  always_comb begin
    stage_d = stage_q;
    if (clear || done) begin
      stage_d = STAGE_RST;
    end else if (wantHit) begin
      stage_d = stage_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage_q <= STAGE_RST;
    end else begin
      stage_q <= stage_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  done_last_a: assert property (done |=> stage_q == STAGE_RST)
    else $error("finished chain did not restart");
  advance_hit_a: assert property (
    (stage_q != STAGE_RST) && !$past(clear) && (stage_q != $past(stage_q))
      |-> $past(wantHit) && (stage_q == $past(stage_q) + 3'h1))
    else $error("chain advanced without the awaited channel");
endmodule

// >>> tb/sbeu_partner.sv
// behavioural model of the monitored core and system bus comparators
module sbeu_partner (
  input logic [sbeu_pkg::NCH-1:0] evReq,
  input logic swReq,
  output logic [sbeu_pkg::NCH-1:0][sbeu_pkg::NCOND-1:0] condHit,
  output logic swTraceHit
);
  timeunit 1ns;
  timeprecision 1ps;
  import sbeu_pkg::*;
  // ------------------------------------
  // comparator results
  // ------------------------------------
  // a match reports only kinds the slot owns; idle ones chatter on the rest,
  // so a slot that fails to mask unusable kinds never fires
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      condHit[i] = evReq[i] ? COND_CAP[i] : ~COND_CAP[i];
    end
    swTraceHit = swReq;
  end
endmodule

// >>> tb/sbeu_top_tb.sv
// self-checking bench for the sequential break event unit
module sbeu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbeu_pkg::*;
  // ------------------------------------
  // stimulus and observed signals
  // ------------------------------------
  localparam logic [CHW-1:0] P1 [4] = '{CH2, CH4, CH6, CH11};
  localparam logic [CHW-1:0] P2 [4] = '{CH1, CH3, CH5, CH10};
  localparam logic [CHW-1:0] S1 [4] = '{CH9, CH8, CH18, CH17};
  localparam logic [CHW-1:0] S2 [4] = '{CH8, CH9, CH17, CH18};
  logic clk = 1'b0;
  logic rst = 1'b1;
  sbeu_cpu_mode_t cpuMode = CPU_OFF;
  sbeu_sys_mode_t sysMode = SYS_OFF;
  logic [NCH-1:0][NCOND-1:0] condUse = '1;
  logic [NCH-1:0][NCOND-1:0] condHit;
  logic [NCH-1:0][CNTW-1:0] countTarget = '0;
  logic [NCH-1:0][CHW-1:0] predSel = '0;
  logic [NCH-1:0] countEn = '0, breakEn = '1, traceEn = '0, perfStartEn = '0;
  logic [NCH-1:0] perfStopEn = '0, flagSetEn = '0, flagClrEn = '0, evReq = '0;
  logic swTraceEn = 1'b0;
  logic swReq = 1'b0;
  logic swTraceHit, haltReq, perfStart, perfStop, swTraceReq, cpuMatchFlag;
  logic [NCH-1:0] traceReq, chanSat;
  logic [STGW-1:0] cpuStage, sysStage;
  logic [CHW-1:0] q [$];
  int nMismatch = 0;
  int nTests = 0;
  int nHalt = 0;
  int j;

  sbeu_top dut (.clk, .rst, .cpuMode, .sysMode, .condUse, .condHit, .countEn,
    .countTarget, .breakEn, .traceEn, .perfStartEn, .perfStopEn, .predSel, .flagSetEn,
    .flagClrEn, .swTraceEn, .swTraceHit, .haltReq, .traceReq, .perfStart, .perfStop,
    .swTraceReq, .cpuMatchFlag, .chanSat, .cpuStage, .sysStage);

  sbeu_partner core (.evReq(evReq), .swReq(swReq), .condHit(condHit),
    .swTraceHit(swTraceHit));

  always #25 clk = ~clk;

  // halts are counted once settled, well before the falling edge at which tests look
  always @(posedge clk) begin
    #10;
    if (haltReq === 1'b1) nHalt++;
  end

  // ------------------------------------
  // tasks
  // ------------------------------------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // conditions and the software trace enable stay programmed across resets; break enables are set, other action, count, predecessor and mode settings cleared
  task doReset;
    @(posedge clk);
    #1 rst = 1'b1;
    cpuMode = CPU_OFF;
    sysMode = SYS_OFF;
    {traceEn, perfStartEn, perfStopEn, countEn, flagSetEn, flagClrEn} = '0;
    breakEn = '1;
    countTarget = '0;
    predSel = '0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    nHalt = 0;
  endtask

  task fire(input logic [CHW-1:0] s);
    @(posedge clk);
    #1 evReq[s] = 1'b1;
    @(posedge clk);
    #1 evReq = '0;
  endtask

  task giveVerdict;
    $display("checks %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    nMismatch++;
    giveVerdict;
  end

  // ------------------------------------
  // tests
  // ------------------------------------
  initial begin
    doReset;
    traceEn = '1;
    perfStartEn = '1;
    perfStopEn = '1;
    swTraceEn = 1'b1;
    fire(CH9);
    chk("trace9", traceReq[CH9], 1);
    chk("perfStart", perfStart, 1);
    chk("halt9", haltReq, 1);
    @(posedge clk);
    #1 chk("haltPulse", haltReq, 0);
    fire(CH10);
    chk("trace10", traceReq, 0);
    chk("perfStop", perfStop, 1);
    fire(CH12);
    chk("trace12", traceReq[CH12], 1);
    breakEn = '0;
    fire(CH7);
    chk("halt7", haltReq, 1);
    @(posedge clk);
    #1 swReq = 1'b1;
    @(posedge clk);
    #1 swReq = 1'b0;
    chk("swTrace", swTraceReq, 1);
    $display("test actions done");
    for (int k = 0; k < 14; k++) begin
      doReset;
      q.delete();
      if (k < 4) begin
        q.push_back(P1[k]);
        q.push_back(P2[k]);
      end else if (k < 10) begin
        if (k == 9) q.push_back(CH11);
        if (k >= 8) q.push_back(CH10);
        for (j = (k < 8) ? k - 1 : 6; j >= 1; j--) q.push_back(CHW'(j - 1));
      end else begin
        q.push_back(S1[k - 10]);
        q.push_back(S2[k - 10]);
      end
      if (k < 10) cpuMode = sbeu_cpu_mode_t'(k + 1);
      else sysMode = sbeu_sys_mode_t'(k - 9);
      // reversed order leaves only the first element taken
      for (j = q.size() - 1; j >= 0; j--) fire(q[j]);
      @(negedge clk);
      if (k < 10) chk("early", nHalt, 0);
      else chk("earlySys", nHalt, 0);
      chk("stage", (k < 10) ? cpuStage : sysStage, 1);
      for (j = 1; j < q.size(); j++) fire(q[j]);
      @(negedge clk);
      if (k < 10) chk("chain", nHalt, 1);
      else chk("chainSys", nHalt, 1);
      fire(q[q.size() - 1]);
      @(negedge clk);
      chk("rearm", nHalt, 1);
    end
    $display("test chains done");
    doReset;
    cpuMode = CPU_EXT;
    sysMode = SYS_EXT;
    predSel[CH1] = 4'h2;
    predSel[CH3] = PRED_FLAG;
    predSel[CH17] = 4'hE;
    flagSetEn[CH2] = 1'b1;
    fire(CH1);
    fire(CH3);
    fire(CH17);
    @(negedge clk);
    chk("noPred", nHalt, 0);
    fire(CH2);
    chk("sat2", chanSat[CH2], 1);
    chk("flagSet", cpuMatchFlag, 1);
    fire(CH18);
    @(negedge clk);
    chk("predNoBreak", nHalt, 0);
    fire(CH1);
    @(negedge clk);
    chk("extHalt", nHalt, 1);
    @(posedge clk);
    #1 chk("flagInit", cpuMatchFlag, 0);
    chk("satClr", chanSat, 0);
    fire(CH18);
    fire(CH17);
    @(negedge clk);
    chk("sysExt", nHalt, 2);
    fire(CH2);
    fire(CH3);
    @(negedge clk);
    chk("flagPred", nHalt, 3);
    fire(CH2);
    breakEn[CH9] = 1'b0;
    flagClrEn[CH9] = 1'b1;
    fire(CH9);
    chk("flagClr", cpuMatchFlag, 0);
    fire(CH3);
    @(negedge clk);
    chk("flagGate", nHalt, 3);
    $display("test extended done");
    doReset;
    countEn[CH11] = 1'b1;
    countTarget[CH11] = 8'h03;
    fire(CH11);
    fire(CH11);
    @(negedge clk);
    chk("count2", nHalt, 0);
    fire(CH11);
    @(negedge clk);
    chk("count3", nHalt, 1);
    $display("test count done");
    doReset;
    cpuMode = CPU_2_1;
    sysMode = SYS_9_8;
    fire(CH9);
    fire(CH2);
    fire(CH1);
    @(posedge clk);
    #1 chk("partClr", sysStage, 0);
    chk("pairHalt", nHalt, 1);
    $display("test rearm done");
    giveVerdict;
  end
endmodule
